// >>> rtl/fault_mgr_defs.vh
// Constants for the drive fault manager: register offsets, fields, codes and timing
`ifndef FAULT_MGR_DEFS_VH
`define FAULT_MGR_DEFS_VH
// Register offsets (byte addresses, one word each)
`define REG_CTRL          8'h00
`define REG_TRY_COUNT     8'h04
`define REG_DELAY         8'h08
`define REG_CLEAR_REQ     8'h0c
`define REG_STATUS        8'h10
`define REG_LATEST_CODE   8'h14
`define REG_IRQ_STATUS    8'h18
`define REG_IRQ_MASK      8'h1c
`define REG_HISTORY       8'h20
// Control register fields
`define CTRL_STOP_SEL_LSB 0
`define CTRL_TERM_FN_LSB  4
`define CTRL_RUN_BIT      12
// Fault clear request values
`define CLR_RESET_FAULT   2'h1
`define CLR_CLEAR_BUFFER  2'h2
// Terminal input function that clears a fault
`define TERM_FN_CLEAR     5'h0d
// Highest stop behaviour value allowing keypad stop clear
`define STOP_SEL_MAX      4'h3
// Fault codes
`define CODE_NONE         8'h00
`define CODE_OVERVOLT     8'h05
`define CODE_UNDERVOLT    8'h04
`define CODE_HEATSINK     8'h08
`define CODE_GROUND       8'h0d
// Reset values
`define TRY_COUNT_RST     4'h0
`define DELAY_RST         8'h00
// Restart delay unit: one tick per 100 ms at 20 MHz
`define DELAY_UNIT_MS     100
`define CLK_KHZ           20000
`define TICK_CYCLES       (`DELAY_UNIT_MS * `CLK_KHZ)
// Display flash half period in ticks
`define FLASH_TICKS       4'h5
// Interrupt bits
`define IRQ_FAULT         0
`define IRQ_CLEARED       1
`define IRQ_RESTART       2
`define IRQ_EXHAUSTED     3
`endif

// >>> rtl/drive_fault_manager_auto_restart.v
// Drive fault manager: fault latch, auto-restart timer, clear requests and display
//
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`include "fault_mgr_defs.vh"
module drive_fault_manager_auto_restart #(
    parameter TICK_CYCLES = `TICK_CYCLES
) (
    // Clock and reset
    input  wire        clk_sys,
    input  wire        rstn,
    // Register port
    input  wire [7:0]  addr,
    input  wire [31:0] wdata,
    input  wire        wr_en,
    input  wire        rd_en,
    output reg  [31:0] rdata_ff,
    // Fault sources (asynchronous levels, cause present while high)
    input  wire        undervolt_in,
    input  wire        overvolt_in,
    input  wire        heatsink_in,
    input  wire        ground_in,
    // Keypad and terminal input (asynchronous pins)
    input  wire        esc_key,
    input  wire        stop_key,
    input  wire        term_input,
    // Drive control and display
    output reg         drive_enable_ff,
    output reg         start_pulse_ff,
    output reg  [7:0]  display_code_ff,
    output reg         display_on_ff,
    output reg         fault_led_ff,
    output reg         irq_ff
);
    // Fault states: idle, restart countdown, held for a manual clear
    localparam ST_IDLE = 2'h0;
    localparam ST_WAIT = 2'h1;
    localparam ST_HELD = 2'h2;

    // Class 2 faults need a manual clear
    function is_class2;
        input [7:0] code;
        begin
            is_class2 = (code == `CODE_GROUND);
        end
    endfunction

    // Faults cleared by a zero delay without restart
    function is_bus_heat;
        input [7:0] code;
        begin
            is_bus_heat = (code == `CODE_UNDERVOLT) || (code == `CODE_OVERVOLT) || (code == `CODE_HEATSINK);
        end
    endfunction

    // Two-flop synchronisers for all pin inputs
    // Keys and fault levels arrive unsynchronised, so nothing reads the first stage
    reg [6:0] sync1_ff;
    reg [6:0] sync2_ff;
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            sync1_ff <= 7'h00;
            sync2_ff <= 7'h00;
        end else begin
            sync1_ff <= {term_input, stop_key, esc_key, ground_in, heatsink_in, overvolt_in, undervolt_in};
            sync2_ff <= sync1_ff;
        end
    end
    wire uv_s   = sync2_ff[0];
    wire ov_s   = sync2_ff[1];
    wire hs_s   = sync2_ff[2];
    wire gf_s   = sync2_ff[3];
    wire esc_s  = sync2_ff[4];
    wire stop_s = sync2_ff[5];
    wire term_s = sync2_ff[6];

    // Edge history for the keys and terminal input
    reg esc_d_ff;
    reg stop_d_ff;
    reg term_d_ff;
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            esc_d_ff  <= 1'b0;
            stop_d_ff <= 1'b0;
            term_d_ff <= 1'b0;
        end else begin
            esc_d_ff  <= esc_s;
            stop_d_ff <= stop_s;
            term_d_ff <= term_s;
        end
    end
    wire esc_press  = esc_s & ~esc_d_ff;
    wire stop_press = stop_s & ~stop_d_ff;
    // A full cycle is press then release, so act on the falling edge
    wire term_cycle = ~term_s & term_d_ff;

    // Priority coder: ground fault first, it is the most severe
    reg [7:0] detect_code;
    always @* begin
        if (gf_s)
            detect_code = `CODE_GROUND;
        else if (ov_s)
            detect_code = `CODE_OVERVOLT;
        else if (uv_s)
            detect_code = `CODE_UNDERVOLT;
        else if (hs_s)
            detect_code = `CODE_HEATSINK;
        else
            detect_code = `CODE_NONE;
    end
    wire any_cause = (detect_code != `CODE_NONE);

    // Software registers
    reg [3:0]  stop_sel_ff;
    reg [4:0]  term_fn_ff;
    reg        run_cmd_ff;
    reg [3:0]  try_count_ff;
    reg [7:0]  delay_ff;
    reg [3:0]  irq_mask_ff;
    wire wr_ctrl  = wr_en && (addr == `REG_CTRL);
    wire wr_clr   = wr_en && (addr == `REG_CLEAR_REQ);
    wire sw_reset = wr_clr && (wdata[1:0] == `CLR_RESET_FAULT);
    wire sw_hist  = wr_clr && (wdata[1:0] == `CLR_CLEAR_BUFFER);
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            stop_sel_ff  <= 4'h0;
            term_fn_ff   <= 5'h00;
            run_cmd_ff   <= 1'b0;
            try_count_ff <= `TRY_COUNT_RST;
            delay_ff     <= `DELAY_RST;
            irq_mask_ff  <= 4'h0;
        end else if (wr_en) begin
            if (wr_ctrl) begin
                stop_sel_ff <= wdata[`CTRL_STOP_SEL_LSB+3:`CTRL_STOP_SEL_LSB];
                term_fn_ff  <= wdata[`CTRL_TERM_FN_LSB+4:`CTRL_TERM_FN_LSB];
                run_cmd_ff  <= wdata[`CTRL_RUN_BIT];
            end
            if (addr == `REG_TRY_COUNT)
                try_count_ff <= wdata[3:0];
            if (addr == `REG_DELAY)
                delay_ff <= wdata[7:0];
            if (addr == `REG_IRQ_MASK)
                irq_mask_ff <= wdata[3:0];
        end
    end

    // Manual clear sources; all need the cause gone first
    wire stop_ok   = stop_press && (stop_sel_ff <= `STOP_SEL_MAX);
    wire term_ok   = term_cycle && (term_fn_ff == `TERM_FN_CLEAR);
    wire man_clear = (sw_reset | stop_ok | term_ok) & ~any_cause;

    // Delay tick divider: one enable pulse per delay unit
    // Free-running, so the first countdown step may come early by up to one unit
    reg [21:0] div_ff;
    wire tick = (div_ff == TICK_CYCLES[21:0] - 22'h000001);
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn)
            div_ff <= 22'h000000;
        else if (tick)
            div_ff <= 22'h000000;
        else
            div_ff <= div_ff + 22'h000001;
    end

    // Fault state machine with restart countdown
    reg [1:0] state_ff;
    reg [1:0] nxt_state;
    reg [7:0] fault_code_ff;
    reg [7:0] nxt_fault_code;
    reg [7:0] count_ff;
    reg [7:0] nxt_count;
    reg [3:0] tries_left_ff;
    reg [3:0] nxt_tries_left;
    reg       acked_ff;
    reg       nxt_acked;
    reg       ev_fault;
    reg       ev_cleared;
    reg       ev_restart;
    reg       ev_exhaust;
    always @* begin
        nxt_state      = state_ff;
        nxt_fault_code = fault_code_ff;
        nxt_count      = count_ff;
        nxt_tries_left = tries_left_ff;
        nxt_acked      = acked_ff;
        ev_fault       = 1'b0;
        ev_cleared     = 1'b0;
        ev_restart     = 1'b0;
        ev_exhaust     = 1'b0;
        case (state_ff)
            ST_IDLE: begin
                nxt_tries_left = try_count_ff;
                if (any_cause) begin
                    ev_fault       = 1'b1;
                    nxt_fault_code = detect_code;
                    nxt_acked      = 1'b0;
                    nxt_count      = delay_ff;
                    if (!is_class2(detect_code) && try_count_ff != 4'h0)
                        nxt_state = ST_WAIT;
                    else
                        nxt_state = ST_HELD;
                end
            end
            ST_WAIT: begin
                if (man_clear) begin
                    nxt_state  = ST_IDLE;
                    ev_cleared = 1'b1;
                end else if (count_ff == 8'h00 || delay_ff == 8'h00) begin
                    // Attempt uses a try whether it succeeds or not
                    nxt_tries_left = tries_left_ff - 4'h1;
                    if (delay_ff == 8'h00 && !is_bus_heat(fault_code_ff)) begin
                        nxt_state = ST_HELD;
                    end else if (!any_cause) begin
                        nxt_state  = ST_IDLE;
                        ev_cleared = 1'b1;
                        // Restart only with a nonzero delay
                        ev_restart = (delay_ff != 8'h00);
                    end else if (tries_left_ff == 4'h1) begin
                        nxt_state  = ST_HELD;
                        ev_exhaust = 1'b1;
                    end else begin
                        nxt_count = delay_ff;
                    end
                end else if (tick) begin
                    nxt_count = count_ff - 8'h01;
                end
                if (esc_press)
                    nxt_acked = 1'b1;
            end
            ST_HELD: begin
                if (man_clear) begin
                    nxt_state  = ST_IDLE;
                    ev_cleared = 1'b1;
                end
                if (esc_press)
                    nxt_acked = 1'b1;
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state_ff      <= ST_IDLE;
            fault_code_ff <= `CODE_NONE;
            count_ff      <= 8'h00;
            tries_left_ff <= 4'h0;
            acked_ff      <= 1'b0;
        end else begin
            state_ff      <= nxt_state;
            fault_code_ff <= nxt_fault_code;
            count_ff      <= nxt_count;
            tries_left_ff <= nxt_tries_left;
            acked_ff      <= nxt_acked;
        end
    end
    // Any state but idle is an active fault and keeps the drive stopped
    wire fault_active = (state_ff != ST_IDLE);

    // Latest fault slot and a small history, cleared by request 2
    // A fault raised while another is active is not recorded
    reg [7:0] latest_code_ff;
    reg [7:0] prev_code_ff;
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            latest_code_ff <= `CODE_NONE;
            prev_code_ff   <= `CODE_NONE;
        end else if (ev_fault) begin
            latest_code_ff <= detect_code;
            prev_code_ff   <= latest_code_ff;
        end else if (sw_hist) begin
            latest_code_ff <= `CODE_NONE;
            prev_code_ff   <= `CODE_NONE;
        end
    end

    // Drive run control; start pulse follows a successful auto reset
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            drive_enable_ff <= 1'b0;
            start_pulse_ff  <= 1'b0;
        end else begin
            drive_enable_ff <= run_cmd_ff & ~fault_active & ~any_cause;
            start_pulse_ff  <= ev_restart;
        end
    end

    // Flash timer for code and LED
    // Runs free so code and LED always flash in the same phase
    reg [3:0] flash_cnt_ff;
    reg       flash_ff;
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            flash_cnt_ff <= 4'h0;
            flash_ff     <= 1'b0;
        end else if (tick) begin
            if (flash_cnt_ff == `FLASH_TICKS - 4'h1) begin
                flash_cnt_ff <= 4'h0;
                flash_ff     <= ~flash_ff;
            end else begin
                flash_cnt_ff <= flash_cnt_ff + 4'h1;
            end
        end
    end

    // Display follows state every cycle; LED flashes even after acknowledge
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            display_code_ff <= `CODE_NONE;
            display_on_ff   <= 1'b0;
            fault_led_ff    <= 1'b0;
        end else begin
            display_code_ff <= (fault_active && !acked_ff) ? fault_code_ff : `CODE_NONE;
            display_on_ff   <= fault_active && !acked_ff && flash_ff;
            fault_led_ff    <= fault_active && flash_ff;
        end
    end

    // Sticky interrupt status; a new event wins over a write-one clear
    reg  [3:0] irq_stat_ff;
    wire [3:0] irq_set = {ev_exhaust, ev_restart, ev_cleared, ev_fault};
    wire [3:0] irq_clr = (wr_en && addr == `REG_IRQ_STATUS) ? wdata[3:0] : 4'h0;
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            irq_stat_ff <= 4'h0;
            irq_ff      <= 1'b0;
        end else begin
            irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_set;
            irq_ff      <= |(irq_stat_ff & irq_mask_ff);
        end
    end

    // Read data one cycle after the strobe; unmapped reads give zero
    // Zero when idle so a late sample of the bus never shows stale data
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rdata_ff <= 32'h00000000;
        end else if (rd_en) begin
            case (addr)
                `REG_CTRL:        rdata_ff <= {19'h00000, run_cmd_ff, 3'h0, term_fn_ff, stop_sel_ff};
                `REG_TRY_COUNT:   rdata_ff <= {28'h0000000, try_count_ff};
                `REG_DELAY:       rdata_ff <= {24'h000000, delay_ff};
                `REG_STATUS:      rdata_ff <= {8'h00, count_ff, tries_left_ff, 1'b0, acked_ff, state_ff,
                                               fault_code_ff};
                `REG_LATEST_CODE: rdata_ff <= {24'h000000, latest_code_ff};
                `REG_IRQ_STATUS:  rdata_ff <= {28'h0000000, irq_stat_ff};
                `REG_IRQ_MASK:    rdata_ff <= {28'h0000000, irq_mask_ff};
                `REG_HISTORY:     rdata_ff <= {24'h000000, prev_code_ff};
                default:          rdata_ff <= 32'h00000000;
            endcase
        end else begin
            rdata_ff <= 32'h00000000;
        end
    end
endmodule

// >>> sim/fault_mgr_props.sv
// Concurrent checks on the fault manager ports
`timescale 1ns/1ps
module fault_mgr_props #(
    parameter TICK_CYCLES = 4
) (
    // Clock and reset
    input wire        clk_sys,
    input wire        rstn,
    // Register port
    input wire [7:0]  addr,
    input wire [31:0] wdata,
    input wire        wr_en,
    input wire        rd_en,
    input wire [31:0] rdata_ff,
    // Pins in
    input wire        undervolt_in,
    input wire        overvolt_in,
    input wire        heatsink_in,
    input wire        ground_in,
    input wire        esc_key,
    input wire        stop_key,
    input wire        term_input,
    // Pins out
    input wire        drive_enable_ff,
    input wire        start_pulse_ff,
    input wire [7:0]  display_code_ff,
    input wire        display_on_ff,
    input wire        fault_led_ff,
    input wire        irq_ff
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    // A cause needs three edges through the synchroniser before it can stop the drive
    AST_HALT_SHOWN: assert property (display_code_ff != 8'h00 |-> !drive_enable_ff) else $error("drive on with fault");
    AST_CAUSE_HALT: assert property ((undervolt_in || overvolt_in || heatsink_in || ground_in)[*4]
        |-> !drive_enable_ff) else $error("drive on with cause");
    AST_START_PULSE: assert property (start_pulse_ff |=> !start_pulse_ff) else $error("start pulse too long");
    AST_START_CLEAR: assert property (start_pulse_ff |=> display_code_ff == 8'h00) else $error("start while shown");
    AST_FLASH_CODE: assert property (display_on_ff |-> display_code_ff != 8'h00) else $error("flash without code");
    AST_GROUND_NOAUTO: assert property (display_code_ff == 8'h0d |-> !start_pulse_ff) else $error("ground restart");
    AST_READ_IDLE: assert property (!$past(rd_en) |-> rdata_ff == 32'h0) else $error("read data not idle");
    AST_GROUND_SHOWN: assert property ($rose(display_code_ff == 8'h0d)
        |-> $past(ground_in, 3) || $past(ground_in, 4) || $past(ground_in, 5)) else $error("ground code");
endmodule
bind drive_fault_manager_auto_restart fault_mgr_props #(.TICK_CYCLES(TICK_CYCLES)) fault_mgr_props_inst (
    .clk_sys(clk_sys), .rstn(rstn), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata_ff(rdata_ff), .undervolt_in(undervolt_in), .overvolt_in(overvolt_in), .heatsink_in(heatsink_in),
    .ground_in(ground_in), .esc_key(esc_key), .stop_key(stop_key), .term_input(term_input),
    .drive_enable_ff(drive_enable_ff), .start_pulse_ff(start_pulse_ff), .display_code_ff(display_code_ff),
    .display_on_ff(display_on_ff), .fault_led_ff(fault_led_ff), .irq_ff(irq_ff));

// >>> sim/panel_model.sv
// Keypad and terminal input model
`timescale 1ns/1ps
module panel_model (
    // Clock
    input wire clk_sys,
    // Keys and terminal pin
    output reg esc_key,
    output reg stop_key,
    output reg term_input
);
    // Idle keys at start
    initial begin
        esc_key = 1'b0;
        stop_key = 1'b0;
        term_input = 1'b0;
    end
    // Press held six cycles so the synchroniser sees it, then a full release
    task press(input integer which);
        integer i;
        begin
            for (i = 0; i < 12; i = i + 1) begin
                @(posedge clk_sys);
                esc_key <= (which == 0) && (i < 6);
                stop_key <= (which == 1) && (i < 6);
                term_input <= (which == 2) && (i < 6);
            end
        end
    endtask
endmodule

// >>> sim/tb_drive_fault_manager_auto_restart.sv
// Self-checking bench for the drive fault manager
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_checks = n_checks + 1; if ((g) !== (e)) begin fails = fails + 1; \
    $display("wrong value %s expected %h seen %h", n, e, g); end end
module tb_drive_fault_manager_auto_restart;
    // Bench signals
    reg         clk_sys = 1'b0;
    reg         rstn = 1'b0;
    reg  [7:0]  addr = 8'h00;
    reg  [31:0] wdata = 32'h0;
    reg         wr_en = 1'b0;
    reg         rd_en = 1'b0;
    reg         undervolt_in = 1'b0;
    reg         overvolt_in = 1'b0;
    reg         heatsink_in = 1'b0;
    reg         ground_in = 1'b0;
    reg  [31:0] d;
    reg         p;
    wire [31:0] rdata_ff;
    wire        esc_key, stop_key, term_input, drive_enable_ff, start_pulse_ff, display_on_ff, fault_led_ff, irq_ff;
    wire [7:0]  display_code_ff;
    integer     fails = 0, n_checks = 0, n_start = 0, i, k, t, s0;
    // Clock and start pulse tally
    always #25 clk_sys = ~clk_sys;
    always @(negedge clk_sys) if (start_pulse_ff === 1'b1) n_start = n_start + 1;
    // Short tick so countdowns finish quickly
    drive_fault_manager_auto_restart #(.TICK_CYCLES(4)) drive_fault_manager_auto_restart_inst (
        .clk_sys(clk_sys), .rstn(rstn), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
        .rdata_ff(rdata_ff), .undervolt_in(undervolt_in), .overvolt_in(overvolt_in), .heatsink_in(heatsink_in),
        .ground_in(ground_in), .esc_key(esc_key), .stop_key(stop_key), .term_input(term_input),
        .drive_enable_ff(drive_enable_ff), .start_pulse_ff(start_pulse_ff), .display_code_ff(display_code_ff),
        .display_on_ff(display_on_ff), .fault_led_ff(fault_led_ff), .irq_ff(irq_ff));
    panel_model panel_model_inst (.clk_sys(clk_sys), .esc_key(esc_key), .stop_key(stop_key), .term_input(term_input));
    // Bus cycles
    task wr(input [7:0] a, input [31:0] v);
        begin
            @(posedge clk_sys);
            addr <= a; wdata <= v; wr_en <= 1'b1;
            @(posedge clk_sys);
            wr_en <= 1'b0;
        end
    endtask
    task rd(input [7:0] a);
        begin
            @(posedge clk_sys);
            addr <= a; rd_en <= 1'b1;
            @(posedge clk_sys);
            rd_en <= 1'b0;
            #1 d = rdata_ff;
        end
    endtask
    task end_sim;
        begin
            $display("checks %0d mismatches %0d", n_checks, fails);
            if (fails == 0 && n_checks > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask
    // Poll status until the fault state matches, bounded
    task wait_state(input [1:0] s);
        begin
            rd(8'h10);
            for (i = 0; i < 300 && d[9:8] !== s; i = i + 1) rd(8'h10);
            `CHK("state", s, d[9:8])
            if (d[9:8] !== s) end_sim;
        end
    endtask
    initial begin
        repeat (5) @(posedge clk_sys);
        rstn <= 1'b1;
        rd(8'h04); `CHK("tries rst", 32'h0, d)
        rd(8'h08); `CHK("delay rst", 32'h0, d)
        rd(8'h3c); `CHK("unmapped", 32'h0, d)
        wr(8'h1c, 32'hf);
        wr(8'h00, 32'h10d4);
        wr(8'h04, 32'h2);
        wr(8'h08, 32'h1);
        // Ground fault is never cleared by the timer
        @(posedge clk_sys) ground_in <= 1'b1;
        wait_state(2'h2);
        `CHK("gf code", 8'h0d, d[7:0])
        `CHK("gf shown", 8'h0d, display_code_ff)
        `CHK("gf irq", 1'b1, irq_ff)
        `CHK("gf halt", 1'b0, drive_enable_ff)
        @(posedge clk_sys) ground_in <= 1'b0;
        t = 0;
        p = display_on_ff;
        for (k = 0; k < 60; k = k + 1) begin
            @(posedge clk_sys) #1;
            if (display_on_ff !== p) t = t + 1;
            p = display_on_ff;
        end
        `CHK("code flashing", 1'b1, t > 1)
        rd(8'h10); `CHK("gf held", 2'h2, d[9:8])
        panel_model_inst.press(1);
        rd(8'h10); `CHK("stop refused", 2'h2, d[9:8])
        panel_model_inst.press(2);
        wait_state(2'h0);
        wr(8'h18, 32'hf);
        rd(8'h18); `CHK("irq clr", 32'h0, d)
        `CHK("irq low", 1'b0, irq_ff)
        $display("ground test done");
        // Undervoltage with auto restart
        wr(8'h00, 32'h1003);
        wr(8'h08, 32'h2);
        @(posedge clk_sys) undervolt_in <= 1'b1;
        wait_state(2'h1);
        `CHK("uv code", 8'h04, d[7:0])
        rd(8'h14); `CHK("latest", 32'h4, d)
        @(posedge clk_sys) undervolt_in <= 1'b0;
        for (k = 0; k < 200 && start_pulse_ff !== 1'b1; k = k + 1) @(posedge clk_sys) #1;
        `CHK("start", 1'b1, start_pulse_ff)
        if (start_pulse_ff !== 1'b1) end_sim;
        repeat (3) @(posedge clk_sys);
        #1 `CHK("running", 1'b1, drive_enable_ff)
        $display("restart test done");
        // Last try fails, fault held, then acknowledged and cleared by stop
        wr(8'h04, 32'h1);
        wr(8'h08, 32'h1);
        @(posedge clk_sys) undervolt_in <= 1'b1;
        wait_state(2'h2);
        `CHK("tries left", 4'h0, d[15:12])
        rd(8'h18); `CHK("exhaust irq", 1'b1, d[3])
        @(posedge clk_sys) undervolt_in <= 1'b0;
        panel_model_inst.press(0);
        repeat (2) @(posedge clk_sys);
        #1 `CHK("blank", 8'h00, display_code_ff)
        `CHK("flash off", 1'b0, display_on_ff)
        rd(8'h10); `CHK("acked", 3'h6, d[10:8])
        t = 0;
        p = fault_led_ff;
        for (k = 0; k < 60; k = k + 1) begin
            @(posedge clk_sys) #1;
            if (fault_led_ff !== p) t = t + 1;
            p = fault_led_ff;
        end
        `CHK("led flashing", 1'b1, t > 1)
        panel_model_inst.press(1);
        wait_state(2'h0);
        $display("exhaust test done");
        // Zero delay clears bus and heat faults with no start
        wr(8'h08, 32'h0);
        wr(8'h04, 32'hf);
        s0 = n_start;
        for (k = 0; k < 3; k = k + 1) begin
            @(posedge clk_sys);
            overvolt_in <= (k == 0);
            undervolt_in <= (k == 1);
            heatsink_in <= (k == 2);
            repeat (3) @(posedge clk_sys);
            {overvolt_in, undervolt_in, heatsink_in} <= 3'h0;
            repeat (30) @(posedge clk_sys);
            rd(8'h14); `CHK("code", (k == 0) ? 32'h5 : (k == 1) ? 32'h4 : 32'h8, d)
            rd(8'h10); `CHK("cleared", 2'h0, d[9:8])
        end
        `CHK("no start", s0, n_start)
        rd(8'h20); `CHK("history kept", 32'h4, d)
        wr(8'h0c, 32'h2);
        rd(8'h20); `CHK("history", 32'h0, d)
        $display("zero delay test done");
        // Clear request refused while the cause stands, taken once it is gone
        @(posedge clk_sys) ground_in <= 1'b1;
        wait_state(2'h2);
        wr(8'h0c, 32'h1);
        rd(8'h10); `CHK("clear refused", 2'h2, d[9:8])
        @(posedge clk_sys) ground_in <= 1'b0;
        repeat (4) @(posedge clk_sys);
        wr(8'h0c, 32'h1);
        wait_state(2'h0);
        // Power cycle clears a held fault
        @(posedge clk_sys) ground_in <= 1'b1;
        wait_state(2'h2);
        @(posedge clk_sys) ground_in <= 1'b0;
        @(posedge clk_sys) rstn <= 1'b0;
        @(posedge clk_sys) rstn <= 1'b1;
        rd(8'h10); `CHK("power cycle", 32'h0, d)
        $display("power test done");
        end_sim;
    end
endmodule
